// [rtl/sbe_top.sv]
`timescale 1ns/1ps
// Operation
// - Master mode drives clock and emits eight clock periods per data write.
// - Master clock rate comes from the two rate select bits.
// - Master mode ignores the slave select pin; software selects slaves.
// - Master shifts one bit out and samples one bit in per period.
// - After eighth master clock set complete flag and latch received byte.
// - Every byte end sets the complete flag in every polarity and phase.
// - Slave mode takes clock as an input and times shifts from it.
// - Slave mode data write loads the byte for the next transfer.
// - Slave drives one bit out and captures one bit per clock.
// - Slave latches received byte only once the whole byte is done.
// - Slave byte ends at eighth clock if phase 1, select rise if phase 0.
// - Master select bit set means master role, cleared means slave role.
// - Phase set transmits on leading edge, cleared on trailing edge.
// - Reading the data register clears the complete flag.
// - Data write during a transfer sets collision flag, cleared by software.
module sbe_top import sbe_pkg::*; (
    input  wire logic       i_mclk,        // Core clock, 50 MHz
    input  wire logic       i_sys_rst,     // Synchronous reset, active high
    input  wire logic [7:0] i_sfr_addr,    // Register address
    input  wire logic       i_sfr_wr,      // Register write strobe
    input  wire logic       i_sfr_rd,      // Register read strobe
    input  wire logic [7:0] i_sfr_wdata,   // Register write data
    output logic      [7:0] o_sfr_rdata,   // Register read data, one cycle later
    input  wire logic       i_sclk_link,   // Serial clock pin, slave mode clock
    input  wire logic       i_ss_n,        // Slave select pin, active low
    input  wire logic       i_mosi,        // Master-out pin level
    input  wire logic       i_miso,        // Master-in pin level
    output logic            o_sclk,        // Serial clock drive
    output logic            o_sclk_oe,     // Serial clock enable
    output logic            o_mosi,        // Master-out drive
    output logic            o_mosi_oe,     // Master-out enable
    output logic            o_miso,        // Master-in drive
    output logic            o_miso_oe,     // Master-in enable
    output logic            o_xfer_done    // Complete flag level for the core
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sbe_link_if lnk ();

    logic [7:0] data_reg;
    logic [5:0] cfg_reg;
    logic       tcf_reg;
    logic       write_collision_flag_reg;
    logic       start_reg;
    logic       slv_en_reg;
    logic       pend_reg;
    logic       miso_s1_reg, miso_s2_reg;
    logic       ss_s1_reg, ss_s2_reg, ss_prev_reg;
    logic       tgl_s1_reg, tgl_s2_reg, tgl_prev_reg;
    logic       act_s1_reg, act_s2_reg;
    logic [7:0] rdata_reg;
    logic       sclk_oe_reg, mosi_oe_reg, miso_oe_reg;
    logic       data_wr, data_rd, ctrl_wr, ctrl_rd;
    logic       is_master, enabled, busy, collide;
    logic       slv_evt, ss_rise, slv_cmp, complete;
    logic [7:0] rx_src;
    logic       frame_rst, en_rst;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    assign data_wr   = i_sfr_wr && (i_sfr_addr == SBE_DATA_ADDR);
    assign data_rd   = i_sfr_rd && (i_sfr_addr == SBE_DATA_ADDR);
    assign ctrl_wr   = i_sfr_wr && (i_sfr_addr == SBE_CTRL_ADDR);
    assign ctrl_rd   = i_sfr_rd && (i_sfr_addr == SBE_CTRL_ADDR);
    assign is_master = cfg_reg[SBE_MST_BIT];
    assign enabled   = cfg_reg[SBE_EN_BIT];

    // A transfer counts from the start request until the byte is closed, for a phase 0 slave until its eighth sample
    assign busy    = start_reg | lnk.mst_busy | act_s2_reg;
    assign collide = data_wr && (busy || complete);

    // ------------------------------------------------------------------
    // Pin and link synchronisers
    // ------------------------------------------------------------------
    // Two stages on the master-in and select pins and on the slave toggle and active levels
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            miso_s1_reg <= 1'b0;
            miso_s2_reg <= 1'b0;
            ss_s1_reg   <= 1'b1;
            ss_s2_reg   <= 1'b1;
            ss_prev_reg <= 1'b1;
            tgl_s1_reg  <= 1'b0;
            tgl_s2_reg  <= 1'b0;
            tgl_prev_reg <= 1'b0;
            act_s1_reg  <= 1'b0;
            act_s2_reg  <= 1'b0;
        end else begin
            miso_s1_reg <= i_miso;
            miso_s2_reg <= miso_s1_reg;
            ss_s1_reg   <= i_ss_n;
            ss_s2_reg   <= ss_s1_reg;
            ss_prev_reg <= ss_s2_reg;
            tgl_s1_reg  <= lnk.slv_done_tgl;
            tgl_s2_reg  <= tgl_s1_reg;
            tgl_prev_reg <= tgl_s2_reg;
            act_s1_reg  <= lnk.slv_active;
            act_s2_reg  <= act_s1_reg;
        end
    end

    // ------------------------------------------------------------------
    // Byte completion
    // ------------------------------------------------------------------
    assign slv_evt = tgl_s2_reg ^ tgl_prev_reg;
    assign ss_rise = ss_s2_reg & ~ss_prev_reg;

    // Phase 1 closes at the eighth clock; phase 0 waits for select to rise
    assign slv_cmp = slv_en_reg &&
                     (cfg_reg[SBE_CPHA_BIT] ? slv_evt : ((pend_reg | slv_evt) && ss_rise));
    assign complete = lnk.mst_done | slv_cmp;
    assign rx_src   = lnk.mst_done ? lnk.mst_rx : lnk.slv_rx;

    // Phase 0: a full byte waits here until select returns high
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !slv_en_reg || cfg_reg[SBE_CPHA_BIT] || slv_cmp) pend_reg <= 1'b0;
        else if (slv_evt) pend_reg <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Data register: completion wins; writes during a transfer are dropped
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) data_reg <= SBE_DATA_RST;
        else if (complete) data_reg <= rx_src;
        else if (data_wr && !busy) data_reg <= i_sfr_wdata;
    end

    // Configuration bits, written whole
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) cfg_reg <= SBE_CTRL_RST[5:0];
        else if (ctrl_wr) cfg_reg <= i_sfr_wdata[5:0];
    end

    // Complete flag: hardware set beats any clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) tcf_reg <= 1'b0;
        else if (complete) tcf_reg <= 1'b1;
        else if (ctrl_wr) tcf_reg <= i_sfr_wdata[SBE_TCF_BIT];
        else if (data_rd) tcf_reg <= 1'b0;
    end

    // Collision flag: only software clears it
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) write_collision_flag_reg <= 1'b0;
        else if (collide) write_collision_flag_reg <= 1'b1;
        else if (ctrl_wr) write_collision_flag_reg <= i_sfr_wdata[SBE_WRITE_COLLISION_FLAG_BIT];
    end

    // A data write in master mode launches one burst; select is not looked at
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) start_reg <= 1'b0;
        else start_reg <= data_wr && !busy && !complete && enabled && is_master;
    end

    // Read data; in slave mode the low rate bit reads back the select pin
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) rdata_reg <= SBE_UNMAPPED;
        else if (data_rd) rdata_reg <= data_reg;
        else if (ctrl_rd) rdata_reg <= {tcf_reg, write_collision_flag_reg, cfg_reg[5:1],
                                        is_master ? cfg_reg[SBE_RATE_LO] : ss_s2_reg};
        else if (i_sfr_rd) rdata_reg <= SBE_UNMAPPED;
    end

    // ------------------------------------------------------------------
    // Pin direction
    // ------------------------------------------------------------------
    // Master drives clock and master-out; slave drives master-in while selected
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sclk_oe_reg <= 1'b0;
            mosi_oe_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
            slv_en_reg  <= 1'b0;
        end else begin
            sclk_oe_reg <= enabled && is_master;
            mosi_oe_reg <= enabled && is_master;
            miso_oe_reg <= enabled && !is_master && !ss_s2_reg;
            slv_en_reg  <= enabled && !is_master;
        end
    end

    // ------------------------------------------------------------------
    // Engines
    // ------------------------------------------------------------------
    assign lnk.tx_byte = data_reg;
    assign lnk.cpol    = cfg_reg[SBE_CPOL_BIT];
    assign lnk.cpha    = cfg_reg[SBE_CPHA_BIT];
    assign lnk.rate    = cfg_reg[SBE_RATE_HI:SBE_RATE_LO];
    assign lnk.start   = start_reg;

    // The select pin ends a slave frame asynchronously: the link clock stops
    assign frame_rst = i_ss_n | ~slv_en_reg;
    assign en_rst    = ~slv_en_reg;

    sbe_master u_master (
        .i_mclk      (i_mclk),
        .i_sys_rst   (i_sys_rst),
        .i_miso_sync (miso_s2_reg),
        .lnk         (lnk.mst),
        .o_sclk      (o_sclk),
        .o_mosi      (o_mosi)
    );

    sbe_slave u_slave (
        .i_sclk_link (i_sclk_link),
        .i_frame_rst (frame_rst),
        .i_en_rst    (en_rst),
        .i_mosi      (i_mosi),
        .lnk         (lnk.slv),
        .o_miso      (o_miso)
    );

    assign o_sfr_rdata = rdata_reg;
    assign o_sclk_oe   = sclk_oe_reg;
    assign o_mosi_oe   = mosi_oe_reg;
    assign o_miso_oe   = miso_oe_reg;
    assign o_xfer_done = tcf_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [4:0] tog_cnt_reg;
    logic [2:0] hold_cnt_reg;
    logic       sclk_prev_reg;

    // Count clock pin changes per burst and cycles between them
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tog_cnt_reg   <= 5'h00;
            hold_cnt_reg  <= 3'h0;
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= o_sclk;
            if (start_reg) tog_cnt_reg <= 5'h00;
            else if (o_sclk != sclk_prev_reg) tog_cnt_reg <= tog_cnt_reg + 5'h01;
            if (o_sclk != sclk_prev_reg) hold_cnt_reg <= 3'h0;
            else hold_cnt_reg <= hold_cnt_reg + 3'h1;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    a_burst_edge_count: assert property (
        lnk.mst_done |-> (tog_cnt_reg + 5'((o_sclk != sclk_prev_reg) ? 1 : 0)) == SBE_EDGES)
        else $error("master burst did not give eight clock periods");

    a_rate_half_period: assert property (
        (lnk.mst_busy || lnk.mst_done) && (o_sclk != sclk_prev_reg) && (tog_cnt_reg != 5'h00)
        && $stable(lnk.rate) |-> hold_cnt_reg == sbe_half_limit(lnk.rate))
        else $error("serial clock half period does not match rate select");

    a_select_ignored: assert property (
        enabled && is_master && $stable(cfg_reg) |=> !o_miso_oe && o_sclk_oe)
        else $error("master mode reacted to the select pin");

    a_mosi_on_edges: assert property (
        lnk.mst_busy && !$past(start_reg) && $changed(o_mosi) |-> $changed(o_sclk))
        else $error("master-out moved without a clock edge");

    a_master_latch: assert property (
        lnk.mst_done |=> tcf_reg && (data_reg == $past(lnk.mst_rx)))
        else $error("master byte end did not set flag and latch data");

    a_slave_phase1_end: assert property (
        slv_en_reg && cfg_reg[SBE_CPHA_BIT] && slv_evt |=> tcf_reg)
        else $error("phase 1 slave byte end did not set flag");

    a_phase0_waits: assert property (
        slv_en_reg && !cfg_reg[SBE_CPHA_BIT] && !ss_rise && !lnk.mst_done
        |=> $stable(data_reg) || $past(data_wr))
        else $error("phase 0 slave latched data before select rose");

    a_data_no_partial: assert property (
        $changed(data_reg) |-> $past(complete) || $past(data_wr && !busy))
        else $error("data register changed without a write or a byte end");

    a_read_clears: assert property (
        data_rd && !complete && !ctrl_wr |=> !tcf_reg)
        else $error("data read did not clear complete flag");

    a_collision_set: assert property (
        data_wr && busy && !complete |=> write_collision_flag_reg && $stable(data_reg))
        else $error("write during transfer not flagged or not dropped");

    c_master_burst:  cover property (start_reg ##[1:300] lnk.mst_done);
    c_slave_phase1:  cover property (slv_cmp && cfg_reg[SBE_CPHA_BIT]);
    c_slave_phase0:  cover property (slv_cmp && !cfg_reg[SBE_CPHA_BIT]);
    c_collision:     cover property (data_wr && busy);

endmodule : sbe_top

// [rtl/sbe_pkg.sv]
package sbe_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] SBE_DATA_ADDR = 8'h7f;  // spi_shift_data
    localparam logic [7:0] SBE_CTRL_ADDR = 8'hf8;  // serial_port_control
    localparam logic [7:0] SBE_DATA_RST  = 8'h00;
    localparam logic [7:0] SBE_CTRL_RST  = 8'h05;
    localparam logic [7:0] SBE_UNMAPPED  = 8'h00;  // Read value of unmapped addresses

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int SBE_TCF_BIT  = 7;  // transfer_complete_flag
    localparam int SBE_WRITE_COLLISION_FLAG_BIT = 6;  // write_collision_flag
    localparam int SBE_EN_BIT   = 5;  // Interface enable
    localparam int SBE_MST_BIT  = 4;  // master_select_bit
    localparam int SBE_CPOL_BIT = 3;  // Clock idle level
    localparam int SBE_CPHA_BIT = 2;  // Clock phase
    localparam int SBE_RATE_HI  = 1;  // bit_rate_select_high
    localparam int SBE_RATE_LO  = 0;  // bit_rate_select_low

    // ------------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------------
    localparam int         SBE_BYTE_BITS = 8;
    localparam logic [3:0] SBE_LAST_EDGE = 4'hf;   // Sixteen half periods per byte
    localparam logic [2:0] SBE_LAST_BIT  = 3'h7;
    localparam logic [4:0] SBE_EDGES     = 5'h10;

    typedef enum logic {SBE_IDLE, SBE_RUN} sbe_mst_state_type;

    // Core cycles per serial clock half period, minus one: 0, 1, 3 or 7
    function automatic logic [2:0] sbe_half_limit(input logic [1:0] rate);
        sbe_half_limit = 3'((4'h1 << rate) - 4'h1);
    endfunction : sbe_half_limit

endpackage : sbe_pkg

// [rtl/sbe_link_if.sv]
`timescale 1ns/1ps
interface sbe_link_if;
    logic [7:0] tx_byte;       // Byte to send, held by the register side
    logic       cpol;          // Clock idle level
    logic       cpha;          // Clock phase
    logic [1:0] rate;          // Master bit rate select
    logic       start;         // Master burst request, one cycle
    logic       mst_busy;      // Master burst in progress
    logic       mst_done;      // Master byte complete, one cycle
    logic [7:0] mst_rx;        // Master received byte
    logic       slv_done_tgl;  // Slave byte received, toggles in link domain
    logic       slv_active;    // Slave mid-byte, level in link domain
    logic [7:0] slv_rx;        // Slave received byte, stable after toggle

    modport ctl (output tx_byte, cpol, cpha, rate, start,
                 input  mst_busy, mst_done, mst_rx, slv_done_tgl, slv_active, slv_rx);
    modport mst (input  tx_byte, cpol, cpha, rate, start,
                 output mst_busy, mst_done, mst_rx);
    modport slv (input  tx_byte, cpol, cpha,
                 output slv_done_tgl, slv_active, slv_rx);
endinterface : sbe_link_if

// [rtl/sbe_master.sv]
`timescale 1ns/1ps
module sbe_master import sbe_pkg::*; (
    input  wire logic i_mclk,      // Core clock
    input  wire logic i_sys_rst,   // Synchronous reset
    input  wire logic i_miso_sync, // Synchronised receive pin
    sbe_link_if.mst   lnk,         // Register side
    output logic      o_sclk,      // Serial clock, registered
    output logic      o_mosi       // Transmit bit, registered
);
    sbe_mst_state_type state_reg;
    logic [2:0]        div_reg;
    logic [3:0]        edge_reg;
    logic [7:0]        tx_reg;
    logic [7:0]        rx_reg;
    logic              sclk_reg;
    logic              done_reg;
    logic              half_end;
    logic              leading;

    // Even half periods end on a leading edge
    assign half_end = (state_reg == SBE_RUN) && (div_reg == sbe_half_limit(lnk.rate));
    assign leading  = ~edge_reg[0];

    // Burst sequencing: sixteen half periods, then back to idle
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_reg <= SBE_IDLE;
        end else begin
            case (state_reg)
                SBE_IDLE: if (lnk.start) state_reg <= SBE_RUN;
                SBE_RUN:  if (half_end && edge_reg == SBE_LAST_EDGE) state_reg <= SBE_IDLE;
                default:  state_reg <= SBE_IDLE;
            endcase
        end
    end

    // Rate divider and edge counter
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || state_reg == SBE_IDLE || half_end) div_reg <= 3'h0;
        else div_reg <= div_reg + 3'h1;
        if (i_sys_rst || state_reg == SBE_IDLE) edge_reg <= 4'h0;
        else if (half_end) edge_reg <= edge_reg + 4'h1;
    end

    // Clock pin rests at the idle level between bursts
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) sclk_reg <= 1'b0;
        else if (state_reg == SBE_IDLE) sclk_reg <= lnk.cpol;
        else if (half_end) sclk_reg <= ~sclk_reg;
    end

    // Shift out MSB first; phase picks which edge moves the next bit out
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) tx_reg <= 8'h00;
        else if (lnk.start && state_reg == SBE_IDLE) tx_reg <= lnk.tx_byte;
        else if (half_end && (leading ? (lnk.cpha && edge_reg != 4'h0) : ~lnk.cpha))
            tx_reg <= {tx_reg[6:0], 1'b0};
    end

    // Sample on the opposite edge to the one that shifts
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) rx_reg <= 8'h00;
        else if (half_end && (leading == ~lnk.cpha)) rx_reg <= {rx_reg[6:0], i_miso_sync};
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) done_reg <= 1'b0;
        else done_reg <= half_end && (edge_reg == SBE_LAST_EDGE);
    end

    assign lnk.mst_busy = (state_reg == SBE_RUN);
    assign lnk.mst_done = done_reg;
    assign lnk.mst_rx   = rx_reg;
    assign o_sclk       = sclk_reg;
    assign o_mosi       = tx_reg[7];
endmodule : sbe_master

// [rtl/sbe_slave.sv]
`timescale 1ns/1ps
module sbe_slave import sbe_pkg::*; (
    input  wire logic i_sclk_link,    // Serial clock from the external master
    input  wire logic i_frame_rst,    // Async: select high or slave disabled
    input  wire logic i_en_rst,       // Async: slave disabled
    input  wire logic i_mosi,         // Receive pin
    sbe_link_if.slv   lnk,            // Register side
    output logic      o_miso          // Transmit bit
);
    logic       edge_clk;
    logic [2:0] cnt_reg;
    logic [6:0] rx_sh_reg;
    logic       act_reg;
    logic       tgl_reg;
    logic [7:0] rx_reg;
    logic       miso_reg;
    logic       started_reg;

    // Normalise polarity and phase: rising edge of edge_clk always samples
    assign edge_clk = i_sclk_link ^ lnk.cpol ^ lnk.cpha;

    // Sample edge: one bit in per incoming clock period
    always_ff @(posedge edge_clk or posedge i_frame_rst) begin
        if (i_frame_rst) begin
            cnt_reg   <= 3'h0;
            rx_sh_reg <= 7'h00;
            act_reg   <= 1'b0;
        end else begin
            cnt_reg   <= cnt_reg + 3'h1;
            rx_sh_reg <= {rx_sh_reg[5:0], i_mosi};
            act_reg   <= (cnt_reg != SBE_LAST_BIT);
        end
    end

    // Whole byte captured only at the eighth sample; the toggle survives select
    always_ff @(posedge edge_clk or posedge i_en_rst) begin
        if (i_en_rst) begin
            rx_reg  <= 8'h00;
            tgl_reg <= 1'b0;
        end else if (cnt_reg == SBE_LAST_BIT) begin
            rx_reg  <= {rx_sh_reg, i_mosi};
            tgl_reg <= ~tgl_reg;
        end
    end

    // Shift edge: present bit 7-n, n being the bits sampled so far
    always_ff @(negedge edge_clk or posedge i_frame_rst) begin
        if (i_frame_rst) begin
            miso_reg    <= 1'b0;
            started_reg <= 1'b0;
        end else begin
            miso_reg    <= lnk.tx_byte[~cnt_reg];
            started_reg <= 1'b1;
        end
    end

    // Before the first shift edge bit 7 must already stand on the pin
    assign o_miso           = started_reg ? miso_reg : lnk.tx_byte[7];
    assign lnk.slv_done_tgl = tgl_reg;
    assign lnk.slv_active   = act_reg;
    assign lnk.slv_rx       = rx_reg;
endmodule : sbe_slave

// [verification/sbe_spi_peer.sv]
`timescale 1ns/1ps
// Far-side slave, mode 0, MSB first; the line shows the inverse bit while deselected
module sbe_spi_peer (
    input  wire logic       i_sclk,   // Clock from the master
    input  wire logic       i_sel_n,  // Select from a general purpose pin
    input  wire logic       i_mosi,   // Data from the master
    input  wire logic [7:0] i_tx,     // Byte to return
    output logic            o_miso,   // Data to the master
    output logic      [7:0] o_rx      // Byte received
);
    logic [7:0] sh;
    // Load at select, capture on rising, shift on falling
    always @(negedge i_sel_n) sh = i_tx;
    always @(negedge i_sclk) if (!i_sel_n) sh = sh << 1;
    always @(posedge i_sclk) if (!i_sel_n) o_rx <= {o_rx[6:0], i_mosi};
    assign o_miso = i_sel_n ? ~sh[7] : sh[7];
endmodule : sbe_spi_peer

// [verification/sbe_top_tb.sv]
`timescale 1ns/1ps
module sbe_top_tb import sbe_pkg::*;;
    logic       clk = 0, rst = 1, wr = 0, rd = 0, sck = 0, ssn = 1, mosi = 0, sel_n = 1;
    logic [7:0] addr = 0, wd = 0, rdv, pm_rx, got;
    logic       sclk, soe, mo, moe, so, soe2, done, pmiso;
    int         fail_count = 0, samples_checked = 0;
    // Pin levels resolved from the sbe_top output enables
    wire sp = soe ? sclk : sck;
    wire mp = moe ? mo : mosi;
    wire ip = soe2 ? so : pmiso;
    always #10 clk = ~clk;
    sbe_top sbe_top_i (.i_mclk(clk), .i_sys_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdv), .i_sclk_link(sp), .i_ss_n(ssn),
        .i_mosi(mp), .i_miso(ip), .o_sclk(sclk), .o_sclk_oe(soe), .o_mosi(mo),
        .o_mosi_oe(moe), .o_miso(so), .o_miso_oe(soe2), .o_xfer_done(done));
    sbe_spi_peer sbe_spi_peer_i (.i_sclk(sp), .i_sel_n(sel_n), .i_mosi(mp), .i_tx(8'ha5),
        .o_miso(pmiso), .o_rx(pm_rx));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(string n, logic [7:0] g, logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wreg(logic [7:0] a, logic [7:0] d);
        @(negedge clk) {addr, wd, wr} = {a, d, 1'b1};
        @(negedge clk) wr = 0;
    endtask : wreg
    task automatic rreg(logic [7:0] a);
        @(negedge clk) {addr, rd} = {a, 1'b1};
        @(negedge clk) rd = 0;
        got = rdv;
    endtask : rreg
    task automatic wrap_up;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_master;
        int   n = 0, per = 0, t0 = 0;
        logic pv = 0;
        {sel_n, ssn} = 2'b00;  // Slave select low must not matter here
        wreg(SBE_CTRL_ADDR, 8'h33);
        wreg(SBE_DATA_ADDR, 8'h3c);
        wreg(SBE_DATA_ADDR, 8'hff);  // Lands mid-burst, must be refused
        for (int c = 0; c < 300 && done !== 1'b1; c++) begin
            @(posedge clk) #1;
            if (sclk && !pv) {n, per, t0} = {n + 1, c - t0, c};
            pv = sclk;
        end
        chk("clocks", 8'(n), 8'h08);
        chk("moe", {5'h0, soe, moe, soe2}, 8'h06);
        chk("period", 8'(per), 8'h10);
        chk("peer", pm_rx, 8'h3c);
        rreg(SBE_CTRL_ADDR);
        chk("flags", got & 8'hc0, 8'hc0);
        rreg(SBE_DATA_ADDR);
        chk("rx", got, 8'ha5);
        chk("clear", {7'h0, done}, 8'h00);
        {sel_n, ssn} = 2'b11;
        $display("master test done");
    endtask : t_master
    task automatic t_slave(logic cpha);
        logic [7:0] tx = 8'h5b, rx, mine;
        mine = cpha ? 8'h96 : 8'h69;
        wreg(SBE_CTRL_ADDR, 8'h20 | {5'h0, cpha, 2'h0});
        wreg(SBE_DATA_ADDR, mine);
        #5 ssn = 0;
        for (int i = 7; i >= 0; i--) begin
            if (!cpha) {mosi, rx[i]} = {tx[i], so};
            #3 sck = 1;
            #3 if (cpha) {mosi, rx[i]} = {tx[i], so};
            #3 sck = 0;
            #3;
        end
        repeat (10) @(negedge clk);
        chk("soe", {5'h0, soe, moe, soe2}, 8'h01);
        chk("early", {7'h0, done}, {7'h0, cpha});
        ssn = 1;
        repeat (10) @(negedge clk);
        chk("done", {7'h0, done}, 8'h01);
        chk("miso", rx, mine);
        rreg(SBE_DATA_ADDR);
        chk("srx", got, tx);
        $display("slave test done");
    endtask : t_slave
    initial begin
        repeat (8) @(negedge clk);
        rst = 0;
        rreg(SBE_CTRL_ADDR);
        chk("ctrl", got, SBE_CTRL_RST);
        rreg(8'h10);
        chk("unmapped", got, SBE_UNMAPPED);
        t_master;
        t_slave(1);
        t_slave(0);
        wrap_up;
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        fail_count++;
        wrap_up;
    end
endmodule : sbe_top_tb
